// >>> hw/lcdsd_pkg.sv
// constants shared by the segment display driver
// Summary of operation
// - both pin-function registers reset to zero and take 8-bit writes.
// - zero selects segment pins, all ones selects port pins; nothing else allowed.
// - each pin-function register is written once per reset.
// - display byte holds data in low nibble, blink selects in high nibble.
// - blink bit n+4 pairs with data bit n of the same byte.
// - usable display memory starts at base and spans 24, 32 or 40 bytes.
// - byte offset picks the segment pin, bit picks the common slot.
// - blink needs blink bit, global blink enable and data bit all set.
// - memory bytes not used for display act as plain read/write memory.
// - output enable drives unselect waveform on all common pins and on segment pins not handed to a port; fourth common floats unless four-division.
// - blink period select chooses a 0.5 s or 1.0 s blink cycle.
// - display-on bit turns the display on after output enable.
// - commons cycle by division count; static uses the static common pin.
// - three-division mode uses commons 0 to 2 and floats the fourth.
// - data bits 0 to 3 read in slots 0 to 3; 1 selects.
// - static mode ignores data bits 1 to 3.
// - segment pin count is 24, 32 or 40 matching display memory.
// - segments 24-31 and 32-39 share port 9 and 8 pins when selected.
// - display off unselects, output disable grounds, booster disable stops booster.
// - blink clock comes from the timer tick; lit only while it is one.
package lcdsd_pkg;
   localparam logic [15:0] ADDR_PORT8_FUNC = 16'hff58;
   localparam logic [15:0] ADDR_PORT9_FUNC = 16'hff59;
   localparam logic [15:0] ADDR_MODE     = 16'hff90;
   localparam logic [15:0] ADDR_CLKFRM   = 16'hff91;
   localparam logic [15:0] ADDR_STATSEL  = 16'hff92;
   localparam logic [15:0] ADDR_RAM_BASE = 16'hfa00;
   localparam logic [7:0]  RESET_BYTE    = 8'h00;
   localparam logic [7:0]  PF_SEGMENT    = 8'h00;
   localparam logic [7:0]  PF_PORT       = 8'hff;
   localparam int          BIT_DISP_ON   = 7;
   localparam int          BIT_OUT_EN    = 6;
   localparam int          BIT_BOOST     = 5;
   localparam int          BIT_BLINK_SEL = 4;
   localparam int          BIT_BLINK_EN  = 3;
   localparam int          BIT_MODE0     = 0;
   localparam int          BLINK_TICKS_SHORT = 1;
   localparam int          BLINK_TICKS_LONG  = 2;
   localparam int          SEG_PORT9_FIRST   = 24;
   localparam int          SEG_PORT8_FIRST   = 32;
   typedef enum logic [1:0] {LCDSD_GND, LCDSD_UNSEL, LCDSD_NSEL, LCDSD_SEL} lcdsd_drive_t;
endpackage

// >>> hw/lcdsd_top.sv
// segment display controller: registers, display memory, common and segment drive
`timescale 1ns/1ps
module lcdsd_top #(
   parameter int NUM_SEG   = 40,
   parameter int SHARED    = 1,
   parameter int SLOT_DIV  = 64
) (
   input  wire logic                i_ref_clk,
   input  wire logic                i_resetn,
   input  wire logic                i_wr,
   input  wire logic                i_rd,
   input  wire logic [15:0]         i_addr,
   input  wire logic [7:0]          i_wdata,
   input  wire logic                i_blink_tick,
   input  wire logic                i_four_div,
   output logic [7:0]               o_rdata,
   output logic [1:0]               o_seg [NUM_SEG],
   output logic [1:0]               o_com [4],
   output logic                     o_com_fourth_oe,
   output logic [1:0]               o_scom,
   output logic [7:0]               o_port8,
   output logic [7:0]               o_port9,
   output logic                     o_port8_sel,
   output logic                     o_port9_sel,
   output logic                     o_booster_on
);
   // ****************************
   // registers
   // ****************************
   logic [7:0] p8_func_q, p9_func_q, mode_q, clkfrm_q, statsel_q;
   logic       p8_done_q, p9_done_q;
   logic [7:0] ram_q [NUM_SEG];
   logic       tick_s1_q, tick_s2_q, tick_s3_q, four_s1_q, four_s2_q;
   logic       blink_clk_q;
   logic [1:0] blink_cnt_q;
   logic [15:0] div_q;
   logic [1:0] slot_q;
   wire        in_ram = i_addr >= lcdsd_pkg::ADDR_RAM_BASE &&
                        i_addr < lcdsd_pkg::ADDR_RAM_BASE + 16'(NUM_SEG);
   wire [15:0] ram_off = i_addr - lcdsd_pkg::ADDR_RAM_BASE;

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         p8_func_q <= lcdsd_pkg::RESET_BYTE;
         p9_func_q <= lcdsd_pkg::RESET_BYTE;
         p8_done_q <= 1'b0;
         p9_done_q <= 1'b0;
      end else if (i_wr) begin
         if (i_addr == lcdsd_pkg::ADDR_PORT8_FUNC && !p8_done_q) begin
            p8_func_q <= i_wdata;
            p8_done_q <= 1'b1;
         end else if (i_addr == lcdsd_pkg::ADDR_PORT9_FUNC && !p9_done_q) begin
            p9_func_q <= i_wdata;
            p9_done_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         mode_q    <= lcdsd_pkg::RESET_BYTE;
         clkfrm_q  <= lcdsd_pkg::RESET_BYTE;
         statsel_q <= lcdsd_pkg::RESET_BYTE;
      end else if (i_wr) begin
         if (i_addr == lcdsd_pkg::ADDR_MODE) begin
            mode_q <= i_wdata;
         end else if (i_addr == lcdsd_pkg::ADDR_CLKFRM) begin
            clkfrm_q <= i_wdata;
         end else if (i_addr == lcdsd_pkg::ADDR_STATSEL) begin
            statsel_q <= i_wdata;
         end
      end
   end

   // display memory holds no reset value, like ordinary memory
   always_ff @(posedge i_ref_clk) begin
      if (i_wr && in_ram) begin
         ram_q[ram_off[5:0]] <= i_wdata;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_rdata <= 8'h00;
      end else if (i_rd) begin
         if (in_ram) begin
            o_rdata <= ram_q[ram_off[5:0]];
         end else if (i_addr == lcdsd_pkg::ADDR_MODE) begin
            o_rdata <= mode_q;
         end else if (i_addr == lcdsd_pkg::ADDR_CLKFRM) begin
            o_rdata <= clkfrm_q;
         end else if (i_addr == lcdsd_pkg::ADDR_STATSEL) begin
            o_rdata <= statsel_q;
         end else begin
            o_rdata <= 8'h00;
         end
      end
   end

   // ****************************
   // synchronisers and blink clock
   // ****************************
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         tick_s1_q <= 1'b0;
         tick_s2_q <= 1'b0;
         tick_s3_q <= 1'b0;
         four_s1_q <= 1'b0;
         four_s2_q <= 1'b0;
      end else begin
         tick_s1_q <= i_blink_tick;
         tick_s2_q <= tick_s1_q;
         tick_s3_q <= tick_s2_q;
         four_s1_q <= i_four_div;
         four_s2_q <= four_s1_q;
      end
   end

   // each timer interval tick counts toward a blink half-period
   wire tick_rise = tick_s2_q && !tick_s3_q;
   wire [1:0] blink_len = mode_q[lcdsd_pkg::BIT_BLINK_SEL] ?
                          2'(lcdsd_pkg::BLINK_TICKS_LONG) : 2'(lcdsd_pkg::BLINK_TICKS_SHORT);
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         blink_cnt_q <= 2'd0;
         blink_clk_q <= 1'b1;
      end else if (tick_rise) begin
         if (blink_cnt_q + 2'd1 >= blink_len) begin
            blink_cnt_q <= 2'd0;
            blink_clk_q <= !blink_clk_q;
         end else begin
            blink_cnt_q <= blink_cnt_q + 2'd1;
         end
      end
   end

   // ****************************
   // common slot sequencer
   // ****************************
   // static mode when mode bit 0 is clear; four or three divisions otherwise
   wire       static_mode = !mode_q[lcdsd_pkg::BIT_MODE0];
   wire [1:0] last_slot   = static_mode ? 2'd0 : (four_s2_q ? 2'd3 : 2'd2);
   wire       running     = mode_q[lcdsd_pkg::BIT_OUT_EN];
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         div_q  <= 16'h0000;
         slot_q <= 2'd0;
      end else if (!running) begin
         div_q  <= 16'h0000;
         slot_q <= 2'd0;
      end else if (div_q == 16'(SLOT_DIV - 1)) begin
         div_q  <= 16'h0000;
         slot_q <= (slot_q >= last_slot) ? 2'd0 : slot_q + 2'd1;
      end else begin
         div_q  <= div_q + 16'h0001;
         // static forces slot 0 at once, so a mid-frame switch never reads bits 1 to 3
         slot_q <= static_mode ? 2'd0 : slot_q;
      end
   end

   // ****************************
   // pin drive
   // ****************************
   wire disp_on  = mode_q[lcdsd_pkg::BIT_DISP_ON];
   wire blink_en = mode_q[lcdsd_pkg::BIT_BLINK_EN];
   wire port8_mode = SHARED != 0 && p8_func_q == lcdsd_pkg::PF_PORT;
   wire port9_mode = SHARED != 0 && p9_func_q == lcdsd_pkg::PF_PORT;
   wire [1:0] lvl_idle = running ? 2'(lcdsd_pkg::LCDSD_UNSEL) : 2'(lcdsd_pkg::LCDSD_GND);

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         for (int c = 0; c < 4; c++) begin
            o_com[c] <= 2'(lcdsd_pkg::LCDSD_GND);
         end
         o_scom    <= 2'(lcdsd_pkg::LCDSD_GND);
         o_com_fourth_oe <= 1'b0;
      end else begin
         o_com_fourth_oe <= running && !static_mode && four_s2_q;
         for (int c = 0; c < 4; c++) begin
            if (!running || !disp_on || static_mode) begin
               o_com[c] <= lvl_idle;
            end else begin
               o_com[c] <= (slot_q == 2'(c)) ? 2'(lcdsd_pkg::LCDSD_SEL)
                                             : 2'(lcdsd_pkg::LCDSD_NSEL);
            end
         end
         o_scom <= (running && disp_on && static_mode) ? 2'(lcdsd_pkg::LCDSD_SEL)
                                                       : lvl_idle;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         for (int s = 0; s < NUM_SEG; s++) begin
            o_seg[s] <= 2'(lcdsd_pkg::LCDSD_GND);
         end
      end else begin
         for (int s = 0; s < NUM_SEG; s++) begin
            logic [1:0] bsel;
            logic       dbit, lit, port_pin;
            bsel = static_mode ? 2'd0 : slot_q;
            dbit = ram_q[s][bsel];
            lit  = dbit && (!(blink_en && ram_q[s][bsel + 3'd4]) || blink_clk_q);
            port_pin = (s >= lcdsd_pkg::SEG_PORT8_FIRST) ? port8_mode
                     : (s >= lcdsd_pkg::SEG_PORT9_FIRST) ? port9_mode : 1'b0;
            if (port_pin) begin
               // a pin handed to its port carries no segment drive
               o_seg[s] <= 2'(lcdsd_pkg::LCDSD_GND);
            end else if (!running || !disp_on) begin
               o_seg[s] <= lvl_idle;
            end else begin
               o_seg[s] <= lit ? 2'(lcdsd_pkg::LCDSD_SEL) : 2'(lcdsd_pkg::LCDSD_NSEL);
            end
         end
      end
   end

   // shared pins: port mode hands the pin to the port and grounds its segment drive
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_port8_sel  <= 1'b0;
         o_port9_sel  <= 1'b0;
         o_port8      <= 8'h00;
         o_port9      <= 8'h00;
         o_booster_on <= 1'b0;
      end else begin
         o_port8_sel  <= port8_mode;
         o_port9_sel  <= port9_mode;
         o_port8      <= p8_func_q;
         o_port9      <= p9_func_q;
         o_booster_on <= mode_q[lcdsd_pkg::BIT_BOOST];
      end
   end

   // ****************************
   // checks
   // ****************************
   chk_port8_once: assert property (
      @(posedge i_ref_clk) disable iff (!i_resetn)
      p8_done_q |=> $stable(p8_func_q)) else $error("port 8 function changed twice");

   chk_port9_once: assert property (
      @(posedge i_ref_clk) disable iff (!i_resetn)
      p9_done_q |=> $stable(p9_func_q)) else $error("port 9 function changed twice");

   chk_idle_ground: assert property (
      @(posedge i_ref_clk) disable iff (!i_resetn)
      !running && !$past(running) |=> o_scom == 2'(lcdsd_pkg::LCDSD_GND))
      else $error("static common not grounded");

   chk_output_ground: assert property (
      @(posedge i_ref_clk) disable iff (!i_resetn)
      !running |=> o_com[0] == 2'(lcdsd_pkg::LCDSD_GND) && o_seg[0] == 2'(lcdsd_pkg::LCDSD_GND))
      else $error("pins not grounded with output disabled");

   chk_fourth_float: assert property (
      @(posedge i_ref_clk) disable iff (!i_resetn)
      (!four_s2_q ##1 !four_s2_q) |=> !o_com_fourth_oe) else $error("fourth common driven");

   chk_fourth_driven: assert property (
      @(posedge i_ref_clk) disable iff (!i_resetn)
      running && !static_mode && four_s2_q |=> o_com_fourth_oe)
      else $error("fourth common not driven");

   chk_booster_follow: assert property (
      @(posedge i_ref_clk) disable iff (!i_resetn)
      $rose(mode_q[lcdsd_pkg::BIT_BOOST]) |=> o_booster_on) else $error("booster not started");

   chk_booster_stop: assert property (
      @(posedge i_ref_clk) disable iff (!i_resetn)
      $fell(mode_q[lcdsd_pkg::BIT_BOOST]) |=> !o_booster_on) else $error("booster not stopped");

   chk_slot_range: assert property (
      @(posedge i_ref_clk) disable iff (!i_resetn)
      static_mode && $past(static_mode) |-> slot_q == 2'd0) else $error("static slot moved");

   chk_slot_hold: assert property (
      @(posedge i_ref_clk) disable iff (!i_resetn)
      running && !static_mode && div_q != 16'(SLOT_DIV - 1) |=> $stable(slot_q))
      else $error("slot moved before its time");

   chk_slot_wrap: assert property (
      @(posedge i_ref_clk) disable iff (!i_resetn)
      running && div_q == 16'(SLOT_DIV - 1) && slot_q >= last_slot |=> slot_q == 2'd0)
      else $error("slot sequence did not wrap");

   chk_one_common: assert property (
      @(posedge i_ref_clk) disable iff (!i_resetn)
      running && disp_on && !static_mode ##1 running && disp_on && !static_mode |->
      $onehot({o_com[0] == 2'(lcdsd_pkg::LCDSD_SEL), o_com[1] == 2'(lcdsd_pkg::LCDSD_SEL),
               o_com[2] == 2'(lcdsd_pkg::LCDSD_SEL), o_com[3] == 2'(lcdsd_pkg::LCDSD_SEL)}))
      else $error("common select not one-hot");

   chk_static_scom: assert property (
      @(posedge i_ref_clk) disable iff (!i_resetn)
      running && disp_on && static_mode |=> o_scom == 2'(lcdsd_pkg::LCDSD_SEL))
      else $error("static common not selected");

   chk_seg_off: assert property (
      @(posedge i_ref_clk) disable iff (!i_resetn)
      running && !disp_on ##1 running && !disp_on |-> o_seg[0] == 2'(lcdsd_pkg::LCDSD_UNSEL))
      else $error("segment not unselected");

   chk_pf_reset: assert property (
      @(posedge i_ref_clk) disable iff (!i_resetn)
      !p9_done_q |-> p9_func_q == 8'h00) else $error("port 9 function not cleared");

   chk_port8_reset: assert property (
      @(posedge i_ref_clk) disable iff (!i_resetn)
      !p8_done_q |-> p8_func_q == 8'h00) else $error("port 8 function not cleared");

   chk_port_sel: assert property (
      @(posedge i_ref_clk) disable iff (!i_resetn)
      p8_func_q == 8'hff ##1 p8_func_q == 8'hff |-> o_port8_sel) else $error("port mode missed");

   chk_shared_ground: assert property (
      @(posedge i_ref_clk) disable iff (!i_resetn)
      port8_mode && NUM_SEG > lcdsd_pkg::SEG_PORT8_FIRST |=>
      o_seg[NUM_SEG - 1] == 2'(lcdsd_pkg::LCDSD_GND)) else $error("port pin carries segment");

   chk_blink_hold: assert property (
      @(posedge i_ref_clk) disable iff (!i_resetn)
      !tick_rise |=> $stable(blink_clk_q)) else $error("blink clock moved without tick");

   chk_blink_short: assert property (
      @(posedge i_ref_clk) disable iff (!i_resetn)
      tick_rise && !mode_q[lcdsd_pkg::BIT_BLINK_SEL] |=> blink_clk_q != $past(blink_clk_q))
      else $error("short blink did not toggle");

   chk_read_ram: assert property (
      @(posedge i_ref_clk) disable iff (!i_resetn)
      i_rd && in_ram |=> o_rdata == $past(ram_q[ram_off[5:0]]))
      else $error("display memory read wrong");

   chk_write_ram: assert property (
      @(posedge i_ref_clk) disable iff (!i_resetn)
      i_wr && in_ram |=> ram_q[$past(ram_off[5:0])] == $past(i_wdata))
      else $error("display memory write lost");
endmodule

// >>> verif/lcdsd_panel_model.sv
// passive glass model: latches which pixels light per common slot
`timescale 1ns/1ps
module lcdsd_panel_model #(
   parameter int NUM_SEG = 40
) (
   input  wire logic       i_ref_clk,
   input  wire logic [1:0] i_seg [NUM_SEG],
   input  wire logic [1:0] i_com [4],
   input  wire logic [1:0] i_scom,
   output logic [4:0]      o_lit [NUM_SEG]
);
   // bit 4 is the static common; a pixel lights only when both sides select
   always_ff @(posedge i_ref_clk) begin
      for (int s = 0; s < NUM_SEG; s++) begin
         for (int c = 0; c < 4; c++) begin
            if (i_com[c] == lcdsd_pkg::LCDSD_SEL) begin
               o_lit[s][c] <= (i_seg[s] == lcdsd_pkg::LCDSD_SEL);
            end
         end
         if (i_scom == lcdsd_pkg::LCDSD_SEL) begin
            o_lit[s][4] <= (i_seg[s] == lcdsd_pkg::LCDSD_SEL);
         end
      end
   end
endmodule

// >>> verif/test_lcd_segment_driver.sv
// bench for the segment display driver: register, memory and drive checks
`timescale 1ns/1ps
`define CHK(a, e) begin @(negedge clk); total_checks++; if ((a) !== (e)) begin error_cnt++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_lcd_segment_driver;
   logic       clk = 1'b0;
   logic       rstn = 1'b0;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic [7:0] wdata = 8'h00;
   logic       tick = 1'b0;
   logic       four = 1'b1;
   logic [7:0] rdata, p8, p9;
   logic [1:0] seg [40];
   logic [1:0] com [4];
   logic [1:0] scom;
   logic       com_fourth_oe, p8_sel, p9_sel, boost;
   logic [4:0] lit [40];
   int         error_cnt = 0;
   int         total_checks = 0;
   int         cyc = 0;
   lcdsd_top #(.NUM_SEG(40), .SHARED(1), .SLOT_DIV(4)) uut (
      .i_ref_clk(clk), .i_resetn(rstn), .i_wr(wr), .i_rd(rd), .i_addr(addr),
      .i_wdata(wdata), .i_blink_tick(tick), .i_four_div(four), .o_rdata(rdata),
      .o_seg(seg), .o_com(com), .o_com_fourth_oe(com_fourth_oe), .o_scom(scom),
      .o_port8(p8), .o_port9(p9), .o_port8_sel(p8_sel), .o_port9_sel(p9_sel),
      .o_booster_on(boost));
   lcdsd_panel_model #(.NUM_SEG(40)) panel (
      .i_ref_clk(clk), .i_seg(seg), .i_com(com), .i_scom(scom), .o_lit(lit));
   always #2.5 clk = ~clk;
   // ******************************
   // access tasks
   // ******************************
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr8(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd8(input logic [15:0] a, input logic [7:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      `CHK(rdata, e)
   endtask
   // frames are short with four cycles a slot, forty cycles covers several
   task automatic pulse;
      @(posedge clk);
      tick <= 1'b1;
      wt(10);
      tick <= 1'b0;
      wt(40);
   endtask
   task automatic tally_and_finish;
      $display("checks=%0d errors=%0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   // ******************************
   // main sequence
   // ******************************
   initial begin
      wt(5);
      rstn <= 1'b1;
      `CHK(seg[0], 2'h0)
      `CHK({p8_sel, p9_sel, p8, p9}, 18'h0_0000)
      rd8(lcdsd_pkg::ADDR_PORT8_FUNC, 8'h00);
      wr8(lcdsd_pkg::ADDR_PORT8_FUNC, lcdsd_pkg::PF_PORT);
      wr8(lcdsd_pkg::ADDR_PORT9_FUNC, lcdsd_pkg::PF_SEGMENT);
      wr8(lcdsd_pkg::ADDR_PORT8_FUNC, lcdsd_pkg::PF_SEGMENT);
      wr8(lcdsd_pkg::ADDR_PORT9_FUNC, lcdsd_pkg::PF_PORT);
      wt(2);
      `CHK({p8_sel, p9_sel, p8, p9}, 18'h2_ff00)
      wr8(lcdsd_pkg::ADDR_STATSEL, 8'h03);
      rd8(lcdsd_pkg::ADDR_STATSEL, 8'h03);
      wr8(16'hfa00, 8'h05);
      wr8(16'hfa01, 8'h08);
      wr8(16'hfa27, 8'ha5);
      rd8(16'hfa01, 8'h08);
      rd8(16'hfa27, 8'ha5);
      rd8(16'h1234, 8'h00);
      wr8(lcdsd_pkg::ADDR_MODE, 8'h01);
      wr8(lcdsd_pkg::ADDR_CLKFRM, 8'h00);
      wr8(lcdsd_pkg::ADDR_MODE, 8'h21);
      wt(2);
      `CHK(boost, 1'b1)
      // the booster settling wait is shortened: the block has no timer on it
      wr8(lcdsd_pkg::ADDR_MODE, 8'h61);
      wt(3);
      `CHK({seg[1], com[0], com[3]}, 6'h15)
      wr8(lcdsd_pkg::ADDR_MODE, 8'he1);
      wt(40);
      `CHK(lit[1][3:0], 4'h8)
      `CHK(lit[0][3:0], 4'h5)
      `CHK(com_fourth_oe, 1'b1)
      @(posedge clk);
      four <= 1'b0;
      wt(40);
      `CHK(com_fourth_oe, 1'b0)
      wr8(16'hfa01, 8'h0e);
      wr8(16'hfa18, 8'h01);
      wr8(16'hfa20, 8'h01);
      wr8(16'hfa02, 8'h11);
      wr8(16'hfa03, 8'h01);
      wr8(lcdsd_pkg::ADDR_MODE, 8'he8);
      wt(40);
      `CHK({lit[0][4], lit[1][4]}, 2'h2)
      `CHK({lit[24][4], lit[32][4]}, 2'h2)
      `CHK({lit[2][4], lit[3][4]}, 2'h3)
      pulse();
      `CHK({lit[2][4], lit[3][4]}, 2'h1)
      pulse();
      `CHK(lit[2][4], 1'b1)
      wr8(lcdsd_pkg::ADDR_MODE, 8'hf8);
      pulse();
      `CHK(lit[2][4], 1'b1)
      pulse();
      `CHK(lit[2][4], 1'b0)
      wr8(lcdsd_pkg::ADDR_MODE, 8'h61);
      wt(3);
      `CHK({seg[0], scom}, 4'h5)
      wr8(lcdsd_pkg::ADDR_MODE, 8'h21);
      wt(3);
      `CHK({seg[0], scom, boost}, 5'h01)
      wr8(lcdsd_pkg::ADDR_MODE, 8'h00);
      wt(3);
      `CHK(boost, 1'b0)
      tally_and_finish();
   end
endmodule
